/* File: core/fws_core.sv */
// Purpose: Failsafe watchdog and voltage supervisor
// Assumes: Comparator results and clear pin are asynchronous levels
// Notes: All outputs are active low and come from flops
// How it works
// RULE_01: Supply not valid: monitored voltage ignored, reset and save low.
// RULE_02: Supply lost: timer and voltage monitoring off, save and reset low.
// RULE_03: Valid supply, upper threshold: save high, reset high after timeout.
// RULE_04: Below warning threshold: save low until above upper threshold.
// RULE_05: Below reset threshold: reset low and timer stopped.
// RULE_06: Back above upper threshold after a drop: new power-up sequence.
// RULE_07: Voltage high before supply valid: power-up waits for supply valid.
// RULE_08: Timeout period comes from a divider chain, nominally ten ms.
// RULE_09: Constant clear level: warning output is square wave, twice timeout.
// RULE_10: Timer runs only with supply valid and above reset threshold.
// RULE_11: Falling edge or long low pulse clears timer, warning goes high. Code: clears only after FWS_CLR_MIN_CYC cycles low.
// RULE_12: Each clear before expiry keeps warning high and restarts count.
// RULE_13: No clear within timeout: warning toggles each period, low first.
// RULE_14: No clear in first low half: reset low until clear or power-up.
// RULE_15: Clears ignored until the power-on reset delay is done.
// RULE_16: Reset-threshold drop overrides timer: reset, save low, warning off.
// RULE_17: After a drop, clears ignored until next power-up finished.
// RULE_18: Period counter clears on power-up start, clear and each toggle.
// RULE_19: Clear pin synchronised; each qualifying low pulse gives one event.
`timescale 1ns/1ps
`include "fws_map.svh"
module fws_core
#(
    parameter logic [`FWS_TMR_W-1:0] TIMEOUT_CYCLES =
        `FWS_TMR_W'(`FWS_TIMEOUT_CYC)
)
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input fws_pkg::fws_sense_type sense_i,
    output fws_pkg::fws_out_type out_o
);
    import fws_pkg::*;

    localparam logic [`FWS_CLR_CNT_W-1:0] CLR_LAST =
        `FWS_CLR_CNT_W'(`FWS_CLR_MIN_CYC - 1);

    fws_sense_type sense_s;
    fws_state_type state_q;
    fws_state_type state_d;
    logic [`FWS_CLR_CNT_W-1:0] low_cnt_q;
    logic clr_evt;
    logic accept_clr;
    logic enter_por;
    logic supply_ok;
    logic above_reset;
    logic tmr_run;
    logic tmr_clear;
    logic tmr_done;
    logic reset_n_q;
    logic save_n_q;
    logic to_n_q;

    // True while the state is one of the powered states
    function automatic logic is_active(input fws_state_type st);
        return (st == FWS_ST_POR) || (st == FWS_ST_RUN) ||
               (st == FWS_ST_WARN) || (st == FWS_ST_TRIP);
    endfunction

    // True while reset is released
    function automatic logic is_released(input fws_state_type st);
        return (st == FWS_ST_RUN) || (st == FWS_ST_WARN);
    endfunction

    // Pin and comparator inputs cross into the clock domain
    fws_sync #(
        .WIDTH(`FWS_SENSE_W)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .async_i(sense_i),
        .sync_o(sense_s)
    );

    assign supply_ok = sense_s.supply_valid_level;
    assign above_reset = sense_s.reset_threshold;

    // Low-time counter on the clear pin, saturating at the minimum
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            low_cnt_q <= '0;
        end
        else if (sense_s.watchdog_clear_n)
        begin
            low_cnt_q <= '0; // see RULE_19
        end
        else if (low_cnt_q <= CLR_LAST)
        begin
            low_cnt_q <= low_cnt_q + `FWS_CLR_CNT_W'(1);
        end
    end

    // One event per low pulse that reaches the minimum width
    assign clr_evt = !sense_s.watchdog_clear_n &&
                     (low_cnt_q == CLR_LAST); // see RULE_11 see RULE_19

    // Next state; supply and reset threshold take priority
    always_comb
    begin
        state_d = state_q;
        accept_clr = 1'b0;
        enter_por = 1'b0;
        if (!supply_ok)
        begin
            state_d = FWS_ST_OFF; // see RULE_01 see RULE_02 see RULE_07
        end
        else if (is_active(state_q) && !above_reset)
        begin
            state_d = FWS_ST_DROP; // see RULE_05 see RULE_16
        end
        else
        begin
            unique case (state_q)
                FWS_ST_OFF, FWS_ST_DROP:
                begin
                    // Clears are ignored here
                    if (sense_s.upper_threshold)
                    begin
                        state_d = FWS_ST_POR; // see RULE_03 see RULE_06
                        enter_por = 1'b1;
                    end
                end
                FWS_ST_POR:
                begin
                    // Clears ignored during the power-on delay
                    if (tmr_done)
                    begin
                        state_d = FWS_ST_RUN; // see RULE_15 see RULE_17
                    end
                end
                FWS_ST_RUN:
                begin
                    if (clr_evt)
                    begin
                        accept_clr = 1'b1; // see RULE_12
                    end
                    else if (tmr_done)
                    begin
                        state_d = FWS_ST_WARN; // see RULE_13
                    end
                end
                FWS_ST_WARN:
                begin
                    if (clr_evt)
                    begin
                        accept_clr = 1'b1;
                        state_d = FWS_ST_RUN; // see RULE_11
                    end
                    else if (tmr_done)
                    begin
                        state_d = FWS_ST_TRIP; // see RULE_14
                    end
                end
                FWS_ST_TRIP:
                begin
                    if (clr_evt)
                    begin
                        accept_clr = 1'b1;
                        state_d = FWS_ST_RUN; // see RULE_14
                    end
                end
                default:
                begin
                    state_d = FWS_ST_OFF;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q <= FWS_ST_OFF;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Timer runs only while powered and above the reset threshold
    assign tmr_run = is_active(state_q) && supply_ok &&
                     above_reset; // see RULE_10 see RULE_02
    assign tmr_clear = enter_por || accept_clr; // see RULE_18

    // Timeout period from the divider chain
    fws_period #(
        .LENGTH(TIMEOUT_CYCLES)
    ) u_period (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .run_i(tmr_run),
        .clear_i(tmr_clear),
        .done_o(tmr_done)
    ); // see RULE_08

    // Reset output follows the released states
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            reset_n_q <= `FWS_OUT_LOW;
        end
        else
        begin
            reset_n_q <= is_released(state_d); // see RULE_03 see RULE_14
        end
    end

    // Save output with hysteresis between upper and warning thresholds
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            save_n_q <= `FWS_OUT_LOW;
        end
        else if (!is_active(state_d))
        begin
            save_n_q <= `FWS_OUT_LOW; // see RULE_01 see RULE_16
        end
        else if (sense_s.upper_threshold)
        begin
            save_n_q <= `FWS_OUT_HIGH; // see RULE_03
        end
        else if (!sense_s.warning_threshold)
        begin
            save_n_q <= `FWS_OUT_LOW; // see RULE_04
        end
    end

    // Timeout warning: high until expiry, then toggles each period
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            to_n_q <= `FWS_OUT_HIGH;
        end
        else if (!is_active(state_d) || state_d == FWS_ST_POR)
        begin
            to_n_q <= `FWS_OUT_HIGH; // see RULE_16
        end
        else if (accept_clr || state_q == FWS_ST_POR)
        begin
            to_n_q <= `FWS_OUT_HIGH; // see RULE_11 see RULE_12
        end
        else if (tmr_done)
        begin
            to_n_q <= !to_n_q; // see RULE_09 see RULE_13
        end
    end

    assign out_o.system_reset_n = reset_n_q;
    assign out_o.power_fail_warning_n = save_n_q;
    assign out_o.timeout_warning_n = to_n_q;

    // Checks on the supervisor behaviour
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    a_supply_off_low: assert property ( // see RULE_01
        !supply_ok |=> !reset_n_q && !save_n_q && state_q == FWS_ST_OFF)
        else $error("outputs not low without valid supply");

    a_lost_timer_off: assert property ( // see RULE_02
        !supply_ok |-> !tmr_run ##1 !tmr_run)
        else $error("timer runs without valid supply");

    a_drop_forces: assert property ( // see RULE_16
        supply_ok && is_active(state_q) && !above_reset
        |=> !reset_n_q && !save_n_q && to_n_q && state_q == FWS_ST_DROP)
        else $error("drop did not force outputs");

    a_drop_stops: assert property ( // see RULE_05
        state_q == FWS_ST_DROP |-> !tmr_run && !tmr_done)
        else $error("timer runs after drop");

    a_por_release: assert property ( // see RULE_03
        state_q == FWS_ST_POR && tmr_done && supply_ok && above_reset
        |=> reset_n_q && to_n_q && state_q == FWS_ST_RUN)
        else $error("reset not released after power-on delay");

    a_power_up_start: assert property ( // see RULE_06
        supply_ok && (state_q == FWS_ST_DROP || state_q == FWS_ST_OFF) &&
        sense_s.upper_threshold
        |-> tmr_clear ##1 state_q == FWS_ST_POR && save_n_q && !reset_n_q)
        else $error("power-up did not start");

    a_save_warning: assert property ( // see RULE_04
        supply_ok && !sense_s.upper_threshold && !sense_s.warning_threshold
        |=> !save_n_q)
        else $error("save not low below warning threshold");

    a_clear_ignored: assert property ( // see RULE_15
        state_q == FWS_ST_POR && clr_evt && !tmr_done && supply_ok &&
        above_reset |=> state_q == FWS_ST_POR && !reset_n_q)
        else $error("clear accepted during power-on delay");

    a_clear_restart: assert property ( // see RULE_12
        is_released(state_q) && clr_evt && supply_ok && above_reset
        |=> to_n_q && reset_n_q && state_q == FWS_ST_RUN && !tmr_done)
        else $error("clear did not restart the watchdog");

    a_warn_low: assert property ( // see RULE_13
        state_q == FWS_ST_RUN && tmr_done && !clr_evt && supply_ok &&
        above_reset |=> !to_n_q && reset_n_q)
        else $error("warning did not go low at expiry");

    a_trip_reset: assert property ( // see RULE_14
        state_q == FWS_ST_WARN && tmr_done && !clr_evt && supply_ok &&
        above_reset |=> !reset_n_q && to_n_q && state_q == FWS_ST_TRIP)
        else $error("reset not asserted after low half");

    a_clear_single: assert property ( // see RULE_19
        clr_evt |=> !clr_evt [*2])
        else $error("more than one clear event per pulse");

    c_power_up: cover property (
        state_q == FWS_ST_POR ##1 state_q == FWS_ST_RUN);
    c_trip: cover property (
        state_q == FWS_ST_WARN ##1 state_q == FWS_ST_TRIP);
    c_recover: cover property (
        state_q == FWS_ST_TRIP ##1 state_q == FWS_ST_RUN);
    c_drop: cover property (
        state_q == FWS_ST_RUN ##1 state_q == FWS_ST_DROP);
endmodule // fws_core

/* File: shared/fws_map.svh */
// Purpose: Named constants for the failsafe watchdog supervisor
// Assumes: 250 MHz system clock
// Notes: Times keep their printed unit; cycle counts derive from them
`ifndef FWS_MAP_SVH
`define FWS_MAP_SVH

// Clock rate and period
`define FWS_CLK_MHZ 250
`define FWS_CLK_PERIOD_NS 4

// Nominal timeout period, also the power-on reset delay
`define FWS_TIMEOUT_MS 10
`define FWS_TIMEOUT_CYC (`FWS_TIMEOUT_MS * 1000 * `FWS_CLK_MHZ)

// Least low time of a clear pulse, rounded up to whole cycles
`define FWS_CLR_MIN_NS 150
`define FWS_CLR_MIN_CYC \
    ((`FWS_CLR_MIN_NS + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)

// Widths
`define FWS_CLR_CNT_W 6
`define FWS_TMR_W 32
`define FWS_SENSE_W 5

// Reset values of the output flops
`define FWS_OUT_LOW 1'b0
`define FWS_OUT_HIGH 1'b1

`endif

/* File: shared/fws_pkg.sv */
// Purpose: Types shared by the failsafe watchdog supervisor
// Assumes: Comparator results arrive as digital levels
// Notes: Constants live in fws_map.svh
package fws_pkg;

    // Supervisor states
    typedef enum logic [2:0] {
        FWS_ST_OFF  = 3'b000,
        FWS_ST_POR  = 3'b001,
        FWS_ST_RUN  = 3'b010,
        FWS_ST_WARN = 3'b011,
        FWS_ST_TRIP = 3'b100,
        FWS_ST_DROP = 3'b101
    } fws_state_type;

    // Inputs from the comparators and the supervised processor
    typedef struct packed {
        logic supply_valid_level;
        logic upper_threshold;
        logic warning_threshold;
        logic reset_threshold;
        logic watchdog_clear_n;
    } fws_sense_type;

    // Active-low outputs toward the supervised processor
    typedef struct packed {
        logic system_reset_n;
        logic power_fail_warning_n;
        logic timeout_warning_n;
    } fws_out_type;

endpackage

/* File: core/fws_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous levels
// Assumes: Inputs change slowly compared to the clock
// Notes: Only the second flop is visible outside
`timescale 1ns/1ps
module fws_sync
#(
    parameter int WIDTH = 5
)
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Two stages; first stage feeds only the second
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // fws_sync

/* File: core/fws_period.sv */
// Purpose: Timeout period counter
// Assumes: Length of at least two cycles
// Notes: Restarts from zero on clear, on stop and after each expiry
`timescale 1ns/1ps
`include "fws_map.svh"
module fws_period
#(
    parameter logic [`FWS_TMR_W-1:0] LENGTH = `FWS_TMR_W'(`FWS_TIMEOUT_CYC)
)
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic clear_i,
    output logic done_o
);
    logic [`FWS_TMR_W-1:0] count_q;

    // Expiry pulse on the last cycle of a period
    assign done_o = run_i && !clear_i &&
                    (count_q == LENGTH - `FWS_TMR_W'(1));

    // Tick counter
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            count_q <= '0;
        end
        else if (clear_i || !run_i || done_o)
        begin
            count_q <= '0;
        end
        else
        begin
            count_q <= count_q + `FWS_TMR_W'(1);
        end
    end
endmodule // fws_period

/* File: verif/fws_cpu_model.sv */
// Purpose: Supervised processor that sends watchdog clear pulses
// Assumes: Bench requests a pulse by a one-cycle kick with its length
// Notes: Pin is push-pull from the processor, so it never floats
`timescale 1ns/1ps
module fws_cpu_model
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic kick_i,
    input wire logic hold_i,
    input wire logic [7:0] low_len_i,
    output logic clear_n_o,
    output logic busy_o
);
    logic [7:0] low_cnt_q;

    // Low time of the clear pulse, counted in clock cycles
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            low_cnt_q <= 8'h00;
        else if (kick_i)
            low_cnt_q <= low_len_i;
        else if (low_cnt_q != 8'h00)
            low_cnt_q <= low_cnt_q - 8'h01;
    end

    // Pin low while a pulse runs or the bench holds it low
    assign busy_o = (low_cnt_q != 8'h00);
    assign clear_n_o = !(busy_o || hold_i);
endmodule // fws_cpu_model

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the watchdog supervisor
// Assumes: Short timeout of 64 cycles; outputs 3 to 4 edges after a pin
// Notes: Samples stay a few cycles away from each expected change
`timescale 1ns/1ps
module tb;
    import fws_pkg::*;
    localparam logic [31:0] T = 32'h40;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic sup = 1'b0;
    logic upr = 1'b0;
    logic wrn = 1'b0;
    logic rth = 1'b0;
    logic kick = 1'b0;
    logic hold = 1'b0;
    logic [7:0] low_len = 8'h28;
    logic clr_n;
    logic busy;
    fws_sense_type sense;
    fws_out_type out;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int base = 0;

    // Clock and cycle count
    always #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc <= cyc + 1;

    assign sense = {sup, upr, wrn, rth, clr_n};

    fws_core #(.TIMEOUT_CYCLES(T)) uut
    (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .sense_i(sense),
        .out_o(out)
    );

    fws_cpu_model cpu
    (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .kick_i(kick),
        .hold_i(hold),
        .low_len_i(low_len),
        .clear_n_o(clr_n),
        .busy_o(busy)
    );

    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    // Wait until n cycles after the base mark, 1 ns past the edge
    task automatic at(input int n);
        repeat (base + n - cyc) @(posedge clk_sys_i);
        #1;
    endtask

    // One clear pulse of w cycles, returns a few cycles after it ends
    task automatic pulse(input logic [7:0] w);
        low_len = w;
        kick = 1'b1;
        @(posedge clk_sys_i);
        #1 kick = 1'b0;
        for (int i = 0; i < 200 && busy !== 1'b0; i++)
        begin
            @(posedge clk_sys_i);
            #1;
        end
        repeat (6) @(posedge clk_sys_i);
        #1;
    endtask

    // Power-up with all levels good; optional clear during the delay
    task automatic power_seq(input bit with_kick);
        sup = 1'b1;
        upr = 1'b1;
        wrn = 1'b1;
        rth = 1'b1;
        base = cyc;
        at(8);
        chk(out, 3'b011);
        if (with_kick)
        begin
            pulse(8'h28);
            chk(out, 3'b011);
        end
        at(60);
        chk(out, 3'b011);
        at(76);
        chk(out, 3'b111);
    endtask

    task automatic t_defer();
        upr = 1'b1;
        wrn = 1'b1;
        rth = 1'b1;
        base = cyc;
        at(128);
        chk(out, 3'b001);
        power_seq(1'b1);
    endtask

    // No clear after power-up: warning, then reset, then square wave
    task automatic t_square();
        at(100);
        chk(out, 3'b111);
        at(164);
        chk(out, 3'b110);
        at(228);
        chk(out, 3'b011);
        at(292);
        chk(out, 3'b010);
    endtask

    task automatic t_clear();
        pulse(8'h28);
        chk(out, 3'b111);
        // Back-to-back clears spanning several periods
        repeat (6)
        begin
            pulse(8'h28);
            chk(out, 3'b111);
        end
        base = cyc;
        at(150);
        chk(out, 3'b011);
        pulse(8'h14);
        at(200);
        chk(out, 3'b010);
        // Pin held low gives one event, then the wave resumes
        at(210);
        hold = 1'b1;
        base = cyc;
        at(70);
        chk(out, 3'b111);
        at(135);
        chk(out, 3'b110);
        at(200);
        chk(out, 3'b011);
        hold = 1'b0;
    endtask

    task automatic t_drop();
        base = cyc;
        upr = 1'b0;
        wrn = 1'b0;
        at(8);
        chk({2'b00, out.power_fail_warning_n}, 3'b000);
        wrn = 1'b1;
        at(16);
        chk({2'b00, out.power_fail_warning_n}, 3'b000);
        upr = 1'b1;
        at(24);
        chk({2'b00, out.power_fail_warning_n}, 3'b001);
        // Upper, warning and reset comparators all fall in the same step, so save goes low while reset stays low and timeout warning stays high
        upr = 1'b0;
        wrn = 1'b0;
        rth = 1'b0;
        at(32);
        chk(out, 3'b001);
        pulse(8'h28);
        chk(out, 3'b001);
        at(250);
        chk(out, 3'b001);
        upr = 1'b0;
        rth = 1'b1;
        at(260);
        chk(out, 3'b001);
        power_seq(1'b0);
    endtask

    task automatic t_supply();
        base = cyc;
        sup = 1'b0;
        at(8);
        chk(out, 3'b001);
        at(200);
        chk(out, 3'b001);
        power_seq(1'b0);
        // Clear during the first low half of the warning
        at(140);
        chk(out, 3'b110);
        pulse(8'h28);
        chk(out, 3'b111);
    endtask

    // Cut a hang short
    initial
    begin
        #40000;
        n_errors++;
        summarize();
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        #1 nrst_i = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk(out, 3'b001);
        t_defer();
        t_square();
        t_clear();
        t_drop();
        t_supply();
        summarize();
    end
endmodule // tb
